/* hw/eeprom_pkg.sv */
// Package: constants and types of the two-wire EEPROM target
// Operation
// RULE_01: Sample data bits on clock rising edge
// RULE_02: Change driven data only after falling edge
// RULE_03: Controller keeps serial clock high when idle
// RULE_04: Write-protect high refuses every array write
// RULE_05: Write-protect low allows byte and page writes
// RULE_06: Undriven write-protect reads low, writes enabled
// RULE_07: Array of 2048 bytes, 11-bit address
// RULE_08: Page writes up to 16 bytes, partial allowed
// RULE_09: Self-timed programming ends within 5 ms
// RULE_10: Random and sequential reads are supported
// RULE_11: Serial clock stays within selected mode rate
// RULE_12: Data line only pulled low or released
// RULE_13: Target follows start, stop, acknowledge conventions
package eeprom_pkg;
    // Array geometry
    localparam int ADDR_W = 11;
    localparam int MEM_DEPTH = 2048;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int HI_W = ADDR_W - DATA_W;
    localparam int ROW_W = ADDR_W - PAGE_W;
    // Control byte layout
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam int CTRL_RW_BIT = 0;
    localparam int CTRL_HI_LSB = 1;
    localparam int CTRL_TYPE_LSB = 4;
    // Rise counts inside one nine-bit frame
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Bus mode rates in kHz
    localparam int FSCL_STD_KHZ = 100;
    localparam int FSCL_FAST_KHZ = 400;
    localparam int FSCL_FMP_KHZ = 1000;
    // System clock and programming time
    localparam int CLK_KHZ = 25000;
    localparam int WR_TIME_US = 5000;
    localparam int WR_CYCLES = (WR_TIME_US * CLK_KHZ) / 1000;
    localparam int WR_CNT_W = 17;
    // Pin synchroniser width and reset value: clock and data high, write-protect low
    localparam int SYNC_W = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 3'h6;
    // Synchronised pin group
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } pins_s;
    // Transfer phases
    typedef enum {ST_IDLE, ST_CTRL, ST_ADDR, ST_WDATA, ST_RDATA} xfer_e;
endpackage

/* hw/pin_sync.sv */
// Two-flop synchroniser for the bus pins into the system clock
module pin_sync import eeprom_pkg::*; (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [SYNC_W-1:0] d,
    output logic [SYNC_W-1:0] q
);
    logic [SYNC_W-1:0] meta_q; // First stage, read only by q

    // Two stages, clock and data high, write-protect low after reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= SYNC_RST;
            q <= SYNC_RST;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* hw/link_shift.sv */
// Serial-clock domain: bit capture and data-line drive flop
module link_shift import eeprom_pkg::*; (
    input wire logic scl,
    input wire logic sda_i,
    input wire logic drv_next,
    output logic [DATA_W-1:0] rx_q,
    output logic drv_q
);
    // Shift in the data line on each clock rise
    always_ff @(posedge scl) begin
        rx_q <= {rx_q[DATA_W-2:0], sda_i}; // RULE_01
    end

    // Pull level changes only on a clock fall
    always_ff @(negedge scl) begin
        drv_q <= drv_next; // RULE_02
    end
endmodule

/* hw/two_wire_eeprom_target.sv */
// Two-wire serial EEPROM target: protocol, page buffer, array, write timer
module two_wire_eeprom_target import eeprom_pkg::*; #(
    parameter int WR_CYCLES_P = WR_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic wp,
    output logic busy
);
    // Last timer count of a programming cycle
    localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(WR_CYCLES_P - 1);

    // Pins after synchronisation
    pins_s pin_s;
    logic [SYNC_W-1:0] pin_raw;
    logic scl_p_q; // Previous clock level
    logic sda_p_q; // Previous data level

    // Bus events
    logic rise;
    logic start;
    logic stop;
    logic commit_go;

    // Transfer state
    xfer_e state_q;
    logic [3:0] cnt_q; // Rises seen in the frame
    logic [ADDR_W-1:0] addr_q; // Byte address counter
    logic rw_q; // Read requested
    logic drv_next_q; // Pull wanted at next fall
    logic [DATA_W-1:0] sh_q; // Read byte being sent
    logic [DATA_W-1:0] rd_q; // Array word at address

    // Page buffer and programming
    logic [DATA_W-1:0] pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pvalid_q; // Bytes loaded this page
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic busy_q;
    logic [WR_CNT_W-1:0] tmr_q;
    logic [ROW_W-1:0] cpage_q; // Page being programmed
    logic [PAGE_W-1:0] cidx; // Buffer slot under copy
    logic copy_ph; // Copy phase of programming

    // Link-domain outputs
    logic [DATA_W-1:0] rx_byte;
    logic drv_q;

    // Pull level that sends a data bit
    function automatic logic pull_for(input logic b);
        return ~b;
    endfunction

    // Pins into the system domain
    assign pin_raw = {scl, sda_i, wp};

    // Clock, data and write-protect synchronisers
    pin_sync u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .d(pin_raw),
        .q(pin_s)
    );

    // Capture and drive flops on the serial clock
    link_shift u_link (
        .scl(scl),
        .sda_i(sda_i),
        .drv_next(drv_next_q),
        .rx_q(rx_byte),
        .drv_q(drv_q)
    );

    // Previous pin levels for edge detection
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= pin_s.scl;
            sda_p_q <= pin_s.sda;
        end
    end

    // Oversampled edges; margin holds up to the fastest mode rate
    assign rise = pin_s.scl & ~scl_p_q; // RULE_11
    // Data falls or rises while the clock stays high
    assign start = pin_s.scl & scl_p_q & sda_p_q & ~pin_s.sda; // RULE_13
    assign stop = pin_s.scl & scl_p_q & ~sda_p_q & pin_s.sda; // RULE_13

    // Programming begins at stop after data, unless protected
    assign commit_go = stop & (state_q == ST_WDATA) & (|pvalid_q) & ~pin_s.wp; // RULE_04 RULE_05

    // Protocol engine, stepped on start, stop and each clock rise outside idle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            addr_q <= '0;
            rw_q <= 1'b0;
            drv_next_q <= 1'b0;
            sh_q <= '0;
            pvalid_q <= '0;
        end else if (start) begin
            // New frame, line released
            state_q <= ST_CTRL;
            cnt_q <= 4'h0;
            drv_next_q <= 1'b0;
        end else if (stop) begin
            // End of transfer
            state_q <= ST_IDLE;
            drv_next_q <= 1'b0;
        end else if (rise && state_q != ST_IDLE) begin
            // Frame bit count wraps after the acknowledge
            cnt_q <= (cnt_q == BIT_ACK) ? 4'h0 : cnt_q + 4'h1;
            case (state_q)
                ST_CTRL: begin
                    if (cnt_q == BIT_LAST) begin
                        // Acknowledge own type unless programming
                        if (rx_byte[DATA_W-1:CTRL_TYPE_LSB] == DEV_TYPE && !busy_q) begin
                            drv_next_q <= 1'b1; // RULE_13
                            rw_q <= rx_byte[CTRL_RW_BIT];
                            if (!rx_byte[CTRL_RW_BIT]) begin
                                addr_q[ADDR_W-1:DATA_W] <= rx_byte[CTRL_HI_LSB +: HI_W];
                            end
                        end else begin
                            // Not addressed or busy: stay off the line
                            state_q <= ST_IDLE;
                        end
                    end else if (cnt_q == BIT_ACK) begin
                        if (rw_q) begin
                            // Read from the address counter
                            state_q <= ST_RDATA;
                            sh_q <= rd_q; // RULE_10
                            drv_next_q <= pull_for(rd_q[DATA_W-1]);
                            addr_q <= addr_q + 11'h001;
                        end else begin
                            state_q <= ST_ADDR;
                            drv_next_q <= 1'b0;
                        end
                    end
                end
                ST_ADDR: begin
                    if (cnt_q == BIT_LAST) begin
                        // Word address sets a random position
                        addr_q[DATA_W-1:0] <= rx_byte; // RULE_10
                        pvalid_q <= '0;
                        drv_next_q <= 1'b1;
                    end else if (cnt_q == BIT_ACK) begin
                        state_q <= ST_WDATA;
                        drv_next_q <= 1'b0;
                    end
                end
                ST_WDATA: begin
                    if (cnt_q == BIT_LAST) begin
                        if (!pin_s.wp) begin
                            // Buffer the byte; column wraps in the page
                            pbuf[addr_q[PAGE_W-1:0]] <= rx_byte; // RULE_08
                            pvalid_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                            addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 4'h1;
                            drv_next_q <= 1'b1; // RULE_05
                        end else begin
                            // Protected: byte refused with no acknowledge
                            drv_next_q <= 1'b0; // RULE_04 RULE_06
                        end
                    end else if (cnt_q == BIT_ACK) begin
                        drv_next_q <= 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (cnt_q < BIT_LAST) begin
                        // Next bit, most significant first
                        drv_next_q <= pull_for(sh_q[DATA_W-2]);
                        sh_q <= {sh_q[DATA_W-2:0], 1'b0};
                    end else if (cnt_q == BIT_LAST) begin
                        // Release for the controller's acknowledge
                        drv_next_q <= 1'b0;
                    end else if (!rx_byte[0]) begin
                        // Acknowledged: continue with the next byte
                        sh_q <= rd_q; // RULE_10
                        drv_next_q <= pull_for(rd_q[DATA_W-1]);
                        addr_q <= addr_q + 11'h001;
                    end else begin
                        // Not acknowledged: read ends
                        state_q <= ST_IDLE;
                        drv_next_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Self-timed programming cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy_q <= 1'b0;
            tmr_q <= '0;
            cpage_q <= '0;
        end else if (commit_go) begin
            busy_q <= 1'b1;
            tmr_q <= '0;
            cpage_q <= addr_q[ADDR_W-1:PAGE_W];
        end else if (busy_q) begin
            // Ends on its own at the programming time
            if (tmr_q == WR_LAST) begin
                busy_q <= 1'b0; // RULE_09
            end else begin
                tmr_q <= tmr_q + 17'h00001;
            end
        end
    end

    // First sixteen timer counts copy the buffer
    assign copy_ph = busy_q & (tmr_q[WR_CNT_W-1:PAGE_W] == '0);
    assign cidx = tmr_q[PAGE_W-1:0];

    // Array write port, only loaded slots
    always_ff @(posedge clk_sys) begin
        if (copy_ph && pvalid_q[cidx]) begin
            mem[{cpage_q, cidx}] <= pbuf[cidx]; // RULE_07 RULE_08
        end
    end

    // Array read at the address counter
    always_ff @(posedge clk_sys) begin
        rd_q <= mem[addr_q]; // RULE_07
    end

    // Open drain: pull low or release, never high
    assign sda_o = 1'b0; // RULE_12
    assign sda_oe = drv_q & (state_q != ST_IDLE); // RULE_12
    assign busy = busy_q;
endmodule

/* dv/eep_chk.sv */
// Checker: port assertions of the two-wire EEPROM target
module eep_chk import eeprom_pkg::*; #(
    parameter int WR_CYCLES_P = WR_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic wp,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int bcnt_q; // Cycles of the busy period
    // Busy period length
    always_ff @(posedge clk_sys) begin
        bcnt_q <= (srst || !busy) ? 0 : bcnt_q + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_pull; sda_o == 1'b0; endproperty
    a_pull: assert property (p_pull) else $error("high drive");
    property p_rst; $fell(srst) |-> !sda_oe && !busy; endproperty
    a_rst: assert property (p_rst) else $error("active at reset");
    property p_rise; $rose(sda_oe) |-> !scl; endproperty
    a_rise: assert property (p_rise) else $error("pull in high clock");
    property p_hold; $rose(scl) |=> $stable(sda_oe) [*3]; endproperty
    a_hold: assert property (p_hold) else $error("moved after rise");
    property p_mute; busy |-> !sda_oe; endproperty
    a_mute: assert property (p_mute) else $error("answer while busy");
    property p_wp; wp |-> !$rose(busy); endproperty
    a_wp: assert property (p_wp) else $error("protected write");
    property p_max; busy |-> bcnt_q <= WR_CYCLES_P + 4; endproperty
    a_max: assert property (p_max) else $error("busy too long");
    property p_min; $fell(busy) |-> bcnt_q >= WR_CYCLES_P - 4; endproperty
    a_min: assert property (p_min) else $error("busy too short");
endmodule
bind two_wire_eeprom_target eep_chk #(.WR_CYCLES_P(WR_CYCLES_P)) u_chk (.clk_sys(clk_sys),
    .srst(srst), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .busy(busy));

/* dv/bus_ctrl.sv */
// Bus controller model: serial clock and open-drain data pull
module bus_ctrl (
    input wire logic sda_i,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 512; // Half period, below 1 MHz
    logic r; // Sampled bit
    initial scl = 1'b1;
    initial sda_pull = 1'b0;
    // One bit: set while low, sampled while high
    task automatic bit_x(input logic b);
        #(H / 4) sda_pull = !b;
        #(3 * H / 4) scl = 1'b1;
        #(H / 2) r = sda_i;
        #(H / 2) scl = 1'b0;
    endtask
    // Data edge while clock high: start or stop
    task automatic cond(input logic p0, input logic p1);
        #(H / 4) sda_pull = p0;
        #(3 * H / 4) scl = 1'b1;
        #H sda_pull = p1;
        #H scl = !p1;
    endtask
    task automatic start(); cond(1'b0, 1'b1); endtask
    task automatic stop(); cond(1'b1, 1'b0); endtask
    // Byte out MSB first, byte in, ninth bit
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i]);
            q[i] = r;
        end
        bit_x(b9);
        ack = !r;
    endtask
endmodule

/* dv/two_wire_serial_eeprom_target_tb.sv */
// Testbench: writes, reads, protection and polling via the bus model
module two_wire_serial_eeprom_target_tb import eeprom_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WRC = 1000; // Short programming time
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic wp_pin = 1'b0; // May float
    logic scl, sda_pull, sda_o, sda_oe, busy, ack;
    logic [7:0] q; // Byte read
    logic [7:0] mem [2048]; // Expected array
    wire logic wp = (wp_pin === 1'bz) ? 1'b0 : wp_pin;
    wire logic sda_i = !(sda_pull || sda_oe); // Pull-up wire
    int fails = 0;
    int n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    two_wire_eeprom_target #(.WR_CYCLES_P(WRC)) uut (.clk_sys(clk_sys), .srst(srst), .scl(scl),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .busy(busy));
    bus_ctrl ctl (.sda_i(sda_i), .scl(scl), .sda_pull(sda_pull));
    task automatic final_report();
        $display("compared %0d wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a busy level
    task automatic wait_busy(input logic v, input int lim);
        for (int k = 0; busy !== v; k++) begin
            if (k == lim)
                chk(8'(busy), 8'(v));
            if (k == lim)
                final_report();
            @(posedge clk_sys);
        end
    endtask
    // Byte out, acknowledge checked
    task automatic put(input logic [7:0] d, input logic exp);
        ctl.xfer(d, 1'b1, q, ack);
        chk(8'(ack), 8'(exp));
    endtask
    // Start, control byte, word address
    task automatic head(input logic [10:0] a);
        ctl.start();
        put({DEV_TYPE, a[10:8], 1'b0}, 1'b1);
        put(a[7:0], 1'b1);
    endtask
    // Write n random bytes, poll, wait out programming
    task automatic wr(input logic [10:0] a, input int n, input logic ok);
        logic [7:0] d;
        head(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            put(d, ok);
            if (ok) mem[{a[10:4], a[3:0] + 4'(i)}] = d;
        end
        ctl.stop();
        if (!ok)
            repeat (40) @(posedge clk_sys);
        wait_busy(ok, 40);
        if (ok) begin
            ctl.start();
            put({DEV_TYPE, 4'h0}, 1'b0);
            ctl.stop();
            wait_busy(1'b0, WRC + 40);
        end
        chk(8'(busy), 8'h00);
    endtask
    // Random read of n bytes, running address
    task automatic rd(input logic [10:0] a, input int n);
        head(a);
        ctl.start();
        put({DEV_TYPE, 4'h1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            ctl.xfer(8'hFF, i == n - 1, q, ack);
            chk(q, mem[a + 11'(i)]);
        end
        ctl.stop();
    endtask
    // Main sequence
    initial begin
        logic [10:0] a;
        void'($urandom(32'hEA84));
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr(11'h7FC, 4, 1'b1);
        wr(11'h12D, 17, 1'b1);
        rd(11'h120, 16);
        $display("test pages done");
        @(posedge clk_sys);
        wp_pin <= 1'bz;
        wr(11'h000, 2, 1'b1);
        rd(11'h7FD, 5);
        ctl.start();
        put(8'h50, 1'b0);
        ctl.stop();
        $display("test wrap done");
        for (int i = 0; i < 6; i++) begin
            a = 11'($urandom);
            wr(a, 1, 1'b1);
            rd(a, 1);
        end
        @(posedge clk_sys);
        wp_pin <= 1'b1;
        wr(11'h120, 2, 1'b0);
        rd(11'h120, 2);
        $display("test protect done");
        final_report();
    end
endmodule
